// ### src/cmas_cfg.svh
`ifndef CMAS_CFG_SVH
`define CMAS_CFG_SVH
`define CMAS_IND_BIT 15
`define CMAS_PAGE_BIT 10
`define CMAS_OFS_MSB 9
`define CMAS_MOD_BIT 12
`define CMAS_STK_MSB 14
`define CMAS_STK_LSB 13
`define CMAS_YM_MSB 11
`define CMAS_YM_LSB 9
`define CMAS_YL_MSB 8
`define CMAS_YL_LSB 6
`define CMAS_XM_MSB 5
`define CMAS_XM_LSB 3
`define CMAS_XL_MSB 2
`define CMAS_XL_LSB 0
`define CMAS_NOP_WORD 16'h0000
`define CMAS_RST_WORD 16'h0000
`endif

// ### src/cmas_core_addr.sv
// Notes on behaviour
// [R1] Instruction bit 15 picks direct (0) or indirect (1) operand addressing.
// [R2] Direct addressing goes from fetch straight to execute.
// [R3] Instruction bit 10 picks page zero (0) or the current page (1).
// [R4] Fetched word loads the instruction register; memory-reference bits 9..0 go to scratch.
// [R5] Page zero clears scratch bits 15..10; otherwise upper bits stay.
// [R6] On end of phase after loading, enter execute and increment program counter.
// [R7] At fetch start the address register takes the program counter.
// [R8] Indirect phase routes bits 14..0 of the read word into the address register.
// [R9] Bit 15 of an indirect word chains another indirect phase; 0 ends it.
// [R10] Store runs clear-write: read half blocked, transfer register written back.
// [R11] Panel data uses the same clear-write sequence as a store.
// [R12] Above installed capacity reads return zero, no parity error; counters wrap.
// [R13] Address bits 11..0 choose one of 4096 words in the module.
// [R14] Bits 11..9 and 8..6 form the two octal Y digits, one of 64.
// [R15] Bits 5..0 form the two octal X digits.
// [R16] Bit 12 picks lower or upper module; bits 14..13 pick the stack.
// [R17] Exactly one active-low stack select per stack code.
// [R18] A card's decoders are enabled only while its stack select is low.
// [R19] Read strobe drives read lines, write strobe drives write lines.
// [R20] One of eight drivers and one of eight switches per digit.
// [R21] Read and write currents flow in opposite directions.
// [R22] Upper module reverses X direction; Y direction is unchanged.
`timescale 1ns/100ps
`include "cmas_cfg.svh"
module cmas_core_addr #(
  parameter int STACKS_FITTED = 1,
  parameter int WORDS_PER_STACK = 8192
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sequencer
  input wire logic fetch_phase_start,
  input wire logic end_of_phase_flag,
  input wire logic word_valid,
  input wire logic [15:0] mem_word,
  input wire logic mem_ref_op,
  input wire logic store_accumulator_op,
  input wire logic panel_write,
  input wire logic [15:0] store_data,
  // Strobes
  input wire logic y_read_strobe,
  input wire logic y_write_strobe,
  input wire logic x_read_strobe,
  input wire logic x_write_strobe,
  // Status
  output cmas_pkg::cmas_phase_e phase,
  output logic [15:0] memory_address_register,
  output logic [15:0] program_counter,
  output logic [15:0] instruction_register,
  output logic [15:0] scratch_register,
  output logic [15:0] transfer_register,
  output logic [15:0] read_data,
  output logic beyond_capacity,
  output logic parity_error_enable,
  output logic clear_write_active,
  // Stack drive
  output logic basic_stack_select_n,
  output logic second_stack_select_n,
  output logic third_stack_select_n,
  output logic fourth_stack_select_n,
  output logic module_upper,
  output logic [3:0] card_decode_enable,
  output logic [7:0] y_msd_read_line,
  output logic [7:0] y_msd_write_line,
  output logic [7:0] y_lsd_read_line,
  output logic [7:0] y_lsd_write_line,
  output logic [7:0] x_msd_read_line,
  output logic [7:0] x_msd_write_line,
  output logic [7:0] x_lsd_read_line,
  output logic [7:0] x_lsd_write_line
);
  logic rst_meta_r;
  logic rst_sync_b;
  cmas_pkg::cmas_phase_e phase_r;
  logic store_cycle_r;
  logic [15:0] mar_r;
  logic [15:0] pc_r;
  logic [15:0] ir_r;
  logic [15:0] sp1_r;
  logic [15:0] tr_r;
  logic [15:0] rd_r;
  logic [3:0] sel_n;
  logic over_cap;
  logic [15:0] word_eff;
  logic [2:0] ym;
  logic [2:0] yl;
  logic [2:0] xm;
  logic [2:0] xl;
  logic x_rd_eff;
  logic x_wr_eff;
  cmas_pkg::cmas_lines_s ylines;
  cmas_pkg::cmas_lines_s xlines;
  cmas_pkg::cmas_sel_s sel;

  // Reset is released through two flops so that removal is synchronous.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // Words above fitted memory read as a no-operation word. (see [R12])
  assign over_cap = int'(mar_r[14:0]) >= STACKS_FITTED * WORDS_PER_STACK;
  assign word_eff = over_cap ? `CMAS_NOP_WORD : mem_word; // see [R12]

  // Phase sequencing.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      phase_r <= cmas_pkg::PH_FETCH;
    end else if (fetch_phase_start) begin
      phase_r <= cmas_pkg::PH_FETCH;
    end else if (end_of_phase_flag) begin
      case (phase_r)
        cmas_pkg::PH_FETCH: begin
          if (mem_ref_op && ir_r[`CMAS_IND_BIT]) begin
            phase_r <= cmas_pkg::PH_INDIRECT; // see [R1] [R8]
          end else begin
            phase_r <= cmas_pkg::PH_EXECUTE; // see [R2] [R6]
          end
        end
        cmas_pkg::PH_INDIRECT: begin
          if (!sp1_r[`CMAS_IND_BIT]) begin
            phase_r <= cmas_pkg::PH_EXECUTE; // see [R9]
          end
        end
        cmas_pkg::PH_EXECUTE: phase_r <= cmas_pkg::PH_FETCH;
        default: phase_r <= cmas_pkg::PH_FETCH;
      endcase
    end
  end

  // Program counter advances at the end of the fetch phase and wraps naturally.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pc_r <= `CMAS_RST_WORD;
    end else if (end_of_phase_flag && !fetch_phase_start && phase_r == cmas_pkg::PH_FETCH) begin
      pc_r <= pc_r + 16'h0001; // see [R6] [R12]
    end
  end

  // Instruction register takes the fetched word unchanged.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ir_r <= `CMAS_RST_WORD;
    end else if (word_valid && phase_r == cmas_pkg::PH_FETCH) begin
      ir_r <= word_eff; // see [R4]
    end
  end

  // Scratch register holds the operand or address word.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sp1_r <= `CMAS_RST_WORD;
    end else if (word_valid && mem_ref_op && phase_r == cmas_pkg::PH_FETCH) begin
      if (!word_eff[`CMAS_PAGE_BIT]) begin
        sp1_r <= {6'h00, word_eff[`CMAS_OFS_MSB:0]}; // see [R3] [R5]
      end else begin
        sp1_r <= {mar_r[15:10], word_eff[`CMAS_OFS_MSB:0]}; // see [R3] [R4]
      end
    end else if (word_valid && phase_r == cmas_pkg::PH_INDIRECT) begin
      sp1_r <= word_eff; // see [R8] [R9]
    end
  end

  // Address register: program counter at fetch start, else the scratch address.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mar_r <= `CMAS_RST_WORD;
    end else if (fetch_phase_start) begin
      mar_r <= pc_r; // see [R7]
    end else if (end_of_phase_flag && phase_r != cmas_pkg::PH_EXECUTE) begin
      // Bit 15 is the chain flag, not an address bit, so it is dropped.
      mar_r <= {1'b0, sp1_r[14:0]}; // see [R8]
    end
  end

  // Store and panel writes use a clear-write cycle in execute.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      store_cycle_r <= 1'b0;
    end else if (fetch_phase_start) begin
      store_cycle_r <= 1'b0;
    end else if (phase_r == cmas_pkg::PH_EXECUTE && (store_accumulator_op || panel_write)) begin
      store_cycle_r <= 1'b1; // see [R10] [R11]
    end
  end

  // Transfer register; a read in the clear half is kept out of it.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tr_r <= `CMAS_RST_WORD;
    end else if (phase_r == cmas_pkg::PH_EXECUTE && (store_accumulator_op || panel_write)) begin
      tr_r <= store_data; // see [R10] [R11]
    end else if (word_valid && !store_cycle_r) begin
      tr_r <= word_eff; // see [R10]
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rd_r <= `CMAS_RST_WORD;
    end else if (word_valid) begin
      rd_r <= word_eff; // see [R12]
    end
  end

  // Stack decode: one active-low select per stack code.
  assign sel.module_upper = mar_r[`CMAS_MOD_BIT]; // see [R16]
  generate
    for (genvar s = 0; s < 4; s++) begin : g_stk
      assign sel.stack_sel_n[s] = !(mar_r[`CMAS_STK_MSB:`CMAS_STK_LSB] == 2'(s)); // see [R17]
    end
  endgenerate
  assign sel_n = sel.stack_sel_n;

  // Address field split into octal digits.
  assign ym = mar_r[`CMAS_YM_MSB:`CMAS_YM_LSB]; // see [R13] [R14]
  assign yl = mar_r[`CMAS_YL_MSB:`CMAS_YL_LSB]; // see [R14]
  assign xm = mar_r[`CMAS_XM_MSB:`CMAS_XM_LSB]; // see [R15]
  assign xl = mar_r[`CMAS_XL_MSB:`CMAS_XL_LSB]; // see [R15]

  // Upper module swaps the X read and write decoders.
  assign x_rd_eff = sel.module_upper ? x_write_strobe : x_read_strobe; // see [R22]
  assign x_wr_eff = sel.module_upper ? x_read_strobe : x_write_strobe; // see [R22]

  // Any stack code enables the decoders, fitted or not; here one card serves the selected stack.
  cmas_drive_decode u_ydec (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .most_significant_octal_digit(ym),
    .least_significant_octal_digit(yl),
    .enable(!(&sel_n)), // see [R18]
    .read_strobe(y_read_strobe),
    .write_strobe(y_write_strobe),
    .lines(ylines)
  );

  cmas_drive_decode u_xdec (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .most_significant_octal_digit(xm),
    .least_significant_octal_digit(xl),
    .enable(!(&sel_n)), // see [R18]
    .read_strobe(x_rd_eff),
    .write_strobe(x_wr_eff),
    .lines(xlines)
  );

  // Outputs.
  assign phase = phase_r;
  assign memory_address_register = mar_r;
  assign program_counter = pc_r;
  assign instruction_register = ir_r;
  assign scratch_register = sp1_r;
  assign transfer_register = tr_r;
  assign read_data = rd_r;
  assign beyond_capacity = over_cap;
  assign parity_error_enable = !over_cap; // see [R12]
  assign clear_write_active = store_cycle_r;
  assign basic_stack_select_n = sel_n[0];
  assign second_stack_select_n = sel_n[1];
  assign third_stack_select_n = sel_n[2];
  assign fourth_stack_select_n = sel_n[3];
  assign module_upper = sel.module_upper;
  assign card_decode_enable = ~sel_n; // see [R18]
  assign y_msd_read_line = ylines.msd_read;
  assign y_lsd_read_line = ylines.lsd_read;
  assign y_msd_write_line = ylines.msd_write;
  assign y_lsd_write_line = ylines.lsd_write;
  assign x_msd_read_line = xlines.msd_read;
  assign x_lsd_read_line = xlines.lsd_read;
  assign x_msd_write_line = xlines.msd_write;
  assign x_lsd_write_line = xlines.lsd_write;
endmodule // cmas_core_addr

// ### src/cmas_drive_decode.sv
`timescale 1ns/100ps
`include "cmas_cfg.svh"
module cmas_drive_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_sync_b,
  // Digits and enable
  input wire logic [2:0] most_significant_octal_digit,
  input wire logic [2:0] least_significant_octal_digit,
  input wire logic enable,
  // Strobes
  input wire logic read_strobe,
  input wire logic write_strobe,
  // Lines
  output cmas_pkg::cmas_lines_s lines
);
  cmas_pkg::cmas_lines_s lines_nxt;
  always_comb begin
    lines_nxt = '0;
    for (int i = 0; i < 8; i++) begin
      // Read and write groups drive opposite current directions. (see [R21])
      lines_nxt.msd_read[i] = enable && read_strobe && (most_significant_octal_digit == 3'(i)); // see [R19] [R20]
      lines_nxt.lsd_read[i] = enable && read_strobe && (least_significant_octal_digit == 3'(i));
      lines_nxt.msd_write[i] = enable && write_strobe && !read_strobe && (most_significant_octal_digit == 3'(i));
      lines_nxt.lsd_write[i] = enable && write_strobe && !read_strobe && (least_significant_octal_digit == 3'(i));
    end
  end
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      lines <= '0;
    end else begin
      lines <= lines_nxt;
    end
  end
endmodule // cmas_drive_decode

// ### src/cmas_pkg.sv
package cmas_pkg;
  typedef enum logic [1:0] {
    PH_FETCH,
    PH_INDIRECT,
    PH_EXECUTE
  } cmas_phase_e;
  typedef struct packed {
    logic [7:0] msd_read;
    logic [7:0] lsd_read;
    logic [7:0] msd_write;
    logic [7:0] lsd_write;
  } cmas_lines_s;
  typedef struct packed {
    logic [3:0] stack_sel_n;
    logic module_upper;
  } cmas_sel_s;
endpackage

// ### verification/cmas_core_addr_chk.sv
`timescale 1ns/100ps
module cmas_core_addr_chk #(
  parameter int STACKS_FITTED = 1,
  parameter int WORDS_PER_STACK = 8192
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fetch_phase_start,
  input wire logic end_of_phase_flag,
  input wire logic mem_ref_op,
  input wire logic y_read_strobe,
  input wire logic y_write_strobe,
  input wire cmas_pkg::cmas_phase_e phase,
  input wire logic [15:0] memory_address_register,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] instruction_register,
  input wire logic beyond_capacity,
  input wire logic parity_error_enable,
  input wire logic basic_stack_select_n,
  input wire logic second_stack_select_n,
  input wire logic third_stack_select_n,
  input wire logic fourth_stack_select_n,
  input wire logic module_upper,
  input wire logic [3:0] card_decode_enable,
  input wire logic [7:0] y_msd_read_line,
  input wire logic [7:0] y_msd_write_line,
  input wire logic [7:0] y_lsd_read_line,
  input wire logic [7:0] y_lsd_write_line
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] sel_n;
  assign sel_n = {fourth_stack_select_n, third_stack_select_n, second_stack_select_n,
    basic_stack_select_n};
  property p_stack; sel_n == ~(4'h1 << memory_address_register[14:13]); endproperty
  a_stack: assert property (p_stack) else $error("stack select wrong");
  property p_card; card_decode_enable == ~sel_n; endproperty
  a_card: assert property (p_card) else $error("card enable wrong");
  property p_mod; module_upper == memory_address_register[12]; endproperty
  a_mod: assert property (p_mod) else $error("module bit wrong");
  property p_cap;
    beyond_capacity == (memory_address_register[14:0] >= STACKS_FITTED * WORDS_PER_STACK)
      && parity_error_enable == !beyond_capacity;
  endproperty
  a_cap: assert property (p_cap) else $error("capacity flags wrong");
  property p_yrd;
    y_read_strobe |=> y_msd_read_line == 8'h01 << $past(memory_address_register[11:9])
      && y_lsd_read_line == 8'h01 << $past(memory_address_register[8:6])
      && y_msd_write_line == 8'h00;
  endproperty
  a_yrd: assert property (p_yrd) else $error("y read lines wrong");
  property p_ywr;
    y_write_strobe && !y_read_strobe |=> y_lsd_write_line == 8'h01 <<
      $past(memory_address_register[8:6]) && y_msd_read_line == 8'h00 && y_lsd_read_line == 8'h00;
  endproperty
  a_ywr: assert property (p_ywr) else $error("y write lines wrong");
  property p_fetch;
    fetch_phase_start |=> memory_address_register == $past(program_counter) && phase == cmas_pkg::PH_FETCH;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch load wrong");
  property p_mode;
    end_of_phase_flag && !fetch_phase_start && phase == cmas_pkg::PH_FETCH |=>
      phase == ((mem_ref_op && instruction_register[15]) ? cmas_pkg::PH_INDIRECT :
      cmas_pkg::PH_EXECUTE);
  endproperty
  a_mode: assert property (p_mode) else $error("phase after fetch wrong");
  property p_pc;
    phase == cmas_pkg::PH_EXECUTE && $past(phase) == cmas_pkg::PH_FETCH |->
      program_counter == $past(program_counter) + 16'h0001;
  endproperty
  a_pc: assert property (p_pc) else $error("counter step wrong");
  c_ind: cover property (phase == cmas_pkg::PH_INDIRECT ##1 phase == cmas_pkg::PH_INDIRECT);
  c_far: cover property (beyond_capacity);
  c_wr: cover property (y_write_strobe && module_upper);
endmodule // cmas_core_addr_chk
bind cmas_core_addr cmas_core_addr_chk #(.STACKS_FITTED(STACKS_FITTED),
  .WORDS_PER_STACK(WORDS_PER_STACK)) u_chk (.*);

// ### verification/cmas_stack_model.sv
`timescale 1ns/100ps
module cmas_stack_model (
  // Clock
  input wire logic clk,
  // Selects and drive lines
  input wire logic basic_stack_select_n,
  input wire logic module_upper,
  input wire cmas_pkg::cmas_lines_s y_lines,
  input wire cmas_pkg::cmas_lines_s x_lines,
  input wire logic [15:0] wdata,
  // Read answer
  output logic word_valid,
  output logic [15:0] mem_word
);
  logic [15:0] mem [0:8191];
  logic rd_grp;
  logic [12:0] a;
  function automatic logic [2:0] oh(input logic [7:0] v);
    oh = 3'h0;
    for (int i = 0; i < 8; i++) if (v[i]) oh = 3'(i);
  endfunction
  // The upper module takes its X current from the opposite decoder group.
  assign rd_grp = (|y_lines.msd_read) ^ module_upper;
  assign a = {module_upper, oh(y_lines.msd_read | y_lines.msd_write),
    oh(y_lines.lsd_read | y_lines.lsd_write),
    rd_grp ? oh(x_lines.msd_read) : oh(x_lines.msd_write),
    rd_grp ? oh(x_lines.lsd_read) : oh(x_lines.lsd_write)};
  initial begin
    word_valid = 1'b0;
    mem_word = 16'h0000;
  end
  always @(posedge clk) begin
    word_valid <= 1'b0;
    // A released bus shows the last word inverted on alternate cycles, so stale reads stand out.
    mem_word <= ~mem_word;
    if (|y_lines.msd_read) begin
      word_valid <= 1'b1;
      mem_word <= basic_stack_select_n ? 16'h0000 : mem[a];
    end
    if ((|y_lines.msd_write) && !basic_stack_select_n) mem[a] <= wdata;
  end
endmodule // cmas_stack_model

// ### verification/test_core_memory_address_selection.sv
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_core_memory_address_selection;
  logic clk = 1'b0, rst_b, fps, eop, wv, mro, sto, pan, yr, yw, xr, xw, far, pe;
  logic [15:0] mw, sd, mar, pc_o, ir_o, tr, rdd, pc, lf_r = 16'd31038;
  logic [3:0] sel;
  cmas_pkg::cmas_phase_e ph;
  cmas_pkg::cmas_lines_s yl, xl;
  int error_cnt = 0, num_checks = 0;
  always #25 clk = ~clk;
  cmas_core_addr u_dut (.clk(clk), .rst_b(rst_b), .fetch_phase_start(fps),
    .end_of_phase_flag(eop), .word_valid(wv), .mem_word(mw), .mem_ref_op(mro),
    .store_accumulator_op(sto), .panel_write(pan), .store_data(sd), .y_read_strobe(yr),
    .y_write_strobe(yw), .x_read_strobe(xr), .x_write_strobe(xw), .phase(ph),
    .memory_address_register(mar), .program_counter(pc_o), .instruction_register(ir_o),
    .scratch_register(), .transfer_register(tr), .read_data(rdd), .beyond_capacity(far),
    .parity_error_enable(pe), .clear_write_active(), .basic_stack_select_n(sel[0]),
    .second_stack_select_n(sel[1]), .third_stack_select_n(sel[2]),
    .fourth_stack_select_n(sel[3]), .module_upper(), .card_decode_enable(),
    .y_msd_read_line(yl.msd_read), .y_msd_write_line(yl.msd_write),
    .y_lsd_read_line(yl.lsd_read), .y_lsd_write_line(yl.lsd_write),
    .x_msd_read_line(xl.msd_read), .x_msd_write_line(xl.msd_write),
    .x_lsd_read_line(xl.lsd_read), .x_lsd_write_line(xl.lsd_write));
  cmas_stack_model u_mem (.clk(clk), .basic_stack_select_n(sel[0]),
    .module_upper(u_dut.module_upper), .y_lines(yl), .x_lines(xl), .wdata(tr),
    .word_valid(wv), .mem_word(mw));
  function automatic logic [15:0] lf();
    lf_r = {lf_r[14:0], lf_r[15] ^ lf_r[13] ^ lf_r[12] ^ lf_r[10]};
    return lf_r;
  endfunction
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rd();
    {yr, xr} = 2'b11;
    cyc();
    {yr, xr} = 2'b00;
    for (int k = 0; k < 8 && !wv; k++) cyc();
    if (wv !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    cyc();
  endtask
  task automatic step(input int i);
    logic [15:0] ir, w, d, ad, nx;
    int n;
    w = lf();
    ir = {1'(i % 2 == 1), w[14:10], 1'b1, w[8:0]};
    n = 1 + int'(w[9]);
    u_mem.mem[pc[12:0]] = ir;
    // Page zero clears the upper bits; the current page keeps those of the counter.
    ad = ir[10] ? {pc[15:10], ir[9:0]} : {6'h00, ir[9:0]};
    for (int k = 0; k < n && ir[15]; k++) begin
      w = lf();
      nx = (k == n - 1) ? {5'h03, w[10:0]} : {5'h02, w[10:0]};
      if (i == 5 && k == n - 1) nx = {2'b01, w[13:0]};
      u_mem.mem[ad[12:0]] = {1'(k < n - 1), nx[14:0]};
      ad = nx;
    end
    d = lf();
    if (ad < 16'h2000) u_mem.mem[ad[12:0]] = d;
    fps = 1'b1;
    cyc();
    fps = 1'b0;
    `CHK(mar, pc)
    rd();
    `CHK(ir_o, ir)
    eop = 1'b1;
    cyc();
    eop = 1'b0;
    for (int k = 0; k < n && ir[15]; k++) begin
      `CHK(ph, cmas_pkg::PH_INDIRECT)
      rd();
      eop = 1'b1;
      cyc();
      eop = 1'b0;
    end
    `CHK(ph, cmas_pkg::PH_EXECUTE)
    `CHK(mar, ad)
    `CHK(pc_o, pc + 16'h0001)
    `CHK(pe, 1'(ad < 16'h2000))
    if (i % 4 >= 2) begin
      {sto, pan} = (i % 4 == 2) ? 2'b10 : 2'b01;
      sd = ~d;
      cyc();
      {sto, pan} = 2'b00;
      rd();
      `CHK(tr, ~d)
      {yw, xw} = 2'b11;
      cyc();
      {yw, xw} = 2'b00;
      repeat (2) cyc();
      `CHK(u_mem.mem[ad[12:0]], ~d)
    end else begin
      rd();
      `CHK(rdd, (ad < 16'h2000) ? d : 16'h0000)
    end
    pc++;
    $display("test %0d done", i);
  endtask
  initial begin
    {fps, eop, sto, pan, yr, yw, xr, xw, rst_b} = '0;
    mro = 1'b1;
    sd = 16'h0000;
    pc = 16'h0000;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) cyc();
    for (int i = 0; i < 24; i++) step(i);
    report_and_stop();
  end
endmodule // test_core_memory_address_selection
